//--- core/elc_pkg.sv
// Shared constants for the exception and low-power control block
package elc_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IRQ_N = 8;
  localparam int unsigned VEC_W = 4;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_BREAK_WAIT_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_RESET_SOURCE_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_BREAK_FLAG_CONTROL = 12'h008;
  // Field positions
  localparam int unsigned BIT_BREAK_EXITED_WAIT = 1;
  localparam int unsigned BIT_RST_LV = 0;
  localparam int unsigned BIT_RST_BAD_ADDR = 1;
  localparam int unsigned BIT_RST_BAD_OP = 2;
  localparam int unsigned BIT_RST_WATCHDOG = 3;
  localparam int unsigned BIT_RST_PIN = 4;
  localparam int unsigned BIT_RST_POR = 5;
  localparam int unsigned BIT_BREAK_CLEAR_ENABLE = 0;
  // Values after reset
  localparam logic [5:0] RST_SRC_RESET = 6'h20;
  localparam logic RESET_BREAK_CLEAR_ENABLE = 1'b0;
  localparam logic RESET_BREAK_EXITED_WAIT = 1'b0;
  // Crystal cycles of stop recovery
  localparam int unsigned STOP_RECOVERY_CYCLES = 4096;
  // Vector code given to the software trap; hardware source k gets k+1
  localparam logic [VEC_W-1:0] VEC_SOFTWARE_TRAP = 4'h0;
  typedef enum logic [2:0]
  {
    ST_RUN = 3'b000,
    ST_WAIT = 3'b001,
    ST_STOP = 3'b010,
    ST_RECOVER = 3'b011,
    ST_ENTRY = 3'b100
  } elc_state_e;
endpackage

//--- core/elc_sync.sv
// Two-flop synchroniser for levels arriving from pins
`timescale 1ns/100ps
module elc_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= INIT;
      q <= INIT;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

//--- core/elc_top.sv
// Exception arbitration, low-power sequencing and break flag protection
`timescale 1ns/100ps
module elc_top
  import elc_pkg::*;
#(
  parameter int unsigned N_IRQ = IRQ_N,
  parameter int unsigned RECOVERY_CYCLES = STOP_RECOVERY_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_imask,
  input wire logic instr_done,
  input wire logic rti_exec,
  input wire logic swi_exec,
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire logic stack_done,
  input wire logic [N_IRQ-1:0] irq_pending,
  input wire logic [N_IRQ-1:0] irq_enable,
  input wire logic ext_irq_n,
  input wire logic break_mode,
  input wire logic por_evt,
  input wire logic pin_rst_evt,
  input wire logic watchdog_rst_evt,
  input wire logic bad_opcode_evt,
  input wire logic bad_fetch_evt,
  input wire logic low_voltage_evt,
  input wire logic watchdog_disable_cfg,
  input wire logic flag_step1,
  input wire logic flag_step2,
  output logic int_req,
  output logic [VEC_W-1:0] int_vector,
  output logic push_pc_minus1,
  output logic set_imask,
  output logic clear_imask,
  output logic prefetch_discard,
  output logic reset_req,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic clkgen_out_en,
  output logic sys_counter_clr,
  output logic watchdog_run,
  output logic flag_clear_ok,
  output logic two_step_clear
);
  localparam int unsigned CNT_W = $clog2(RECOVERY_CYCLES + 1);

  elc_state_e state_q;
  logic [VEC_W-1:0] vector_q;
  logic hw_q;
  logic [CNT_W-1:0] recover_cnt_q;
  logic recover_irq_q;
  logic rti_seen_q;
  logic prefetch_discard_q;
  logic set_imask_q;
  logic clear_imask_q;
  logic reset_req_q;
  logic break_exited_wait_q;
  logic [5:0] rst_src_q;
  logic break_clear_enable_q;
  logic two_step_armed_q;
  logic two_step_clear_q;
  logic ext_irq_n_s;
  logic [N_IRQ-1:0] irq_live;
  logic any_reset;
  logic any_irq;
  logic apb_acc;
  logic apb_wr;
  logic apb_rd;
  logic hit_bws;
  logic hit_rss;
  logic hit_bfc;
  logic entry_hw;
  logic entry_swi;
  logic [31:0] rdata_d;

  // Lowest index wins
  function automatic logic [VEC_W-1:0] prio_vector(input logic [N_IRQ-1:0] req);
    logic [VEC_W-1:0] v;
    v = '0;
    for (int i = N_IRQ - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        v = VEC_W'(i + 1);
      end
    end
    return v;
  endfunction

  elc_sync #(
    .WIDTH(1),
    .INIT(1'b1)
  ) u_ext_irq_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(ext_irq_n),
    .q(ext_irq_n_s)
  );

  // External pin shares the top-priority source slot
  assign irq_live = (irq_pending | {{(N_IRQ-1){1'b0}}, ~ext_irq_n_s}) & irq_enable;
  assign any_irq = |irq_live;
  assign any_reset = por_evt | pin_rst_evt | watchdog_rst_evt | bad_opcode_evt
    | bad_fetch_evt | low_voltage_evt;

  // Hardware taken only at instruction end while unmasked
  assign entry_hw = instr_done && !cpu_imask && any_irq;
  assign entry_swi = swi_exec;

  assign flag_clear_ok = !break_mode || break_clear_enable_q;

  assign apb_acc = psel && penable;
  assign apb_wr = apb_acc && pwrite;
  assign apb_rd = apb_acc && !pwrite;
  assign hit_bws = paddr == OFS_BREAK_WAIT_STATUS;
  assign hit_rss = paddr == OFS_RESET_SOURCE_STATUS;
  assign hit_bfc = paddr == OFS_BREAK_FLAG_CONTROL;

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = apb_acc && !(hit_bws || hit_rss || hit_bfc);

  // Exception and low-power sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_RUN;
      vector_q <= '0;
      hw_q <= 1'b0;
      recover_cnt_q <= '0;
      recover_irq_q <= 1'b0;
    end
    else if (any_reset)
    begin
      // Resets abandon any latched interrupt or low-power state
      state_q <= ST_RUN;
      hw_q <= 1'b0;
      recover_irq_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_RUN:
        begin
          if (entry_swi)
          begin
            state_q <= ST_ENTRY;
            vector_q <= VEC_SOFTWARE_TRAP;
            hw_q <= 1'b0;
          end
          else if (entry_hw)
          begin
            state_q <= ST_ENTRY;
            vector_q <= prio_vector(irq_live);
            hw_q <= 1'b1;
          end
          else if (wait_exec)
          begin
            state_q <= ST_WAIT;
          end
          else if (stop_exec)
          begin
            state_q <= ST_STOP;
          end
        end
        ST_WAIT:
        begin
          // Mask is cleared on entry, so any enabled source wakes
          if (any_irq)
          begin
            state_q <= ST_ENTRY;
            vector_q <= prio_vector(irq_live);
            hw_q <= 1'b1;
          end
          else if (break_mode)
          begin
            state_q <= ST_RUN;
          end
        end
        ST_STOP:
        begin
          if (!ext_irq_n_s || break_mode)
          begin
            state_q <= ST_RECOVER;
            recover_cnt_q <= CNT_W'(RECOVERY_CYCLES - 1);
            recover_irq_q <= !ext_irq_n_s && irq_enable[0];
          end
        end
        ST_RECOVER:
        begin
          if (recover_cnt_q != '0)
          begin
            recover_cnt_q <= recover_cnt_q - CNT_W'(1);
          end
          else if (recover_irq_q)
          begin
            state_q <= ST_ENTRY;
            vector_q <= prio_vector(irq_live | {{(N_IRQ-1){1'b0}}, 1'b1});
            hw_q <= 1'b1;
          end
          else
          begin
            state_q <= ST_RUN;
          end
        end
        ST_ENTRY:
        begin
          // Latched vector holds until the CPU has stacked
          if (stack_done)
          begin
            state_q <= ST_RUN;
            recover_irq_q <= 1'b0;
          end
        end
        default:
        begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // Entry requests stacking of all registers but index high
  assign int_req = state_q == ST_ENTRY;
  assign int_vector = vector_q;
  assign push_pc_minus1 = hw_q;

  // Mask bit pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      set_imask_q <= 1'b0;
      clear_imask_q <= 1'b0;
    end
    else
    begin
      set_imask_q <= !any_reset && state_q != ST_ENTRY
        && (state_q == ST_RUN ? (entry_swi || entry_hw)
        : (state_q == ST_WAIT ? any_irq
        : (state_q == ST_RECOVER && recover_cnt_q == '0 && recover_irq_q)));
      clear_imask_q <= !any_reset && state_q == ST_RUN && !entry_swi && !entry_hw
        && (wait_exec || stop_exec);
    end
  end
  assign set_imask = set_imask_q;
  assign clear_imask = clear_imask_q;

  // Interrupt taken at the end of a return: its prefetch is waste
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rti_seen_q <= 1'b0;
      prefetch_discard_q <= 1'b0;
    end
    else
    begin
      if (rti_exec)
      begin
        rti_seen_q <= 1'b1;
      end
      else if (instr_done)
      begin
        rti_seen_q <= 1'b0;
      end
      prefetch_discard_q <= state_q == ST_RUN && rti_seen_q && entry_hw && !any_reset;
    end
  end
  assign prefetch_discard = prefetch_discard_q;

  // Reset request pulse, never gated by arbitration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reset_req_q <= 1'b0;
    end
    else
    begin
      reset_req_q <= any_reset;
    end
  end
  assign reset_req = reset_req_q;

  // Clock gating follows state
  assign cpu_clk_en = state_q != ST_WAIT && state_q != ST_STOP
    && state_q != ST_RECOVER;
  assign periph_clk_en = state_q != ST_STOP && state_q != ST_RECOVER;
  assign clkgen_out_en = state_q != ST_STOP;
  assign sys_counter_clr = state_q == ST_STOP;
  assign watchdog_run = !watchdog_disable_cfg && state_q != ST_STOP
    && state_q != ST_RECOVER;

  // Break-exited-wait flag; a new break wins over a clearing write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      break_exited_wait_q <= RESET_BREAK_EXITED_WAIT;
    end
    else if (any_reset)
    begin
      break_exited_wait_q <= 1'b0;
    end
    else if (state_q == ST_WAIT && !any_irq && break_mode)
    begin
      break_exited_wait_q <= 1'b1;
    end
    else if (apb_wr && hit_bws && !pwdata[BIT_BREAK_EXITED_WAIT] && flag_clear_ok)
    begin
      break_exited_wait_q <= 1'b0;
    end
  end

  // Reset source flags survive internal resets; read clears them only while flag_clear_ok is set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_src_q <= RST_SRC_RESET;
    end
    else if (por_evt)
    begin
      rst_src_q <= RST_SRC_RESET;
    end
    else
    begin
      for (int i = 0; i < 6; i++)
      begin
        if (apb_rd && hit_rss && flag_clear_ok)
        begin
          rst_src_q[i] <= 1'b0;
        end
      end
      // Setting after the clear lets a coincident event win
      if (pin_rst_evt)
      begin
        rst_src_q[BIT_RST_PIN] <= 1'b1;
      end
      if (watchdog_rst_evt)
      begin
        rst_src_q[BIT_RST_WATCHDOG] <= 1'b1;
      end
      if (bad_opcode_evt)
      begin
        rst_src_q[BIT_RST_BAD_OP] <= 1'b1;
      end
      if (bad_fetch_evt)
      begin
        rst_src_q[BIT_RST_BAD_ADDR] <= 1'b1;
      end
      if (low_voltage_evt)
      begin
        rst_src_q[BIT_RST_LV] <= 1'b1;
      end
    end
  end

  // Break clear enable control bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      break_clear_enable_q <= RESET_BREAK_CLEAR_ENABLE;
    end
    else if (apb_wr && hit_bfc)
    begin
      break_clear_enable_q <= pwdata[BIT_BREAK_CLEAR_ENABLE];
    end
  end

  // Two-step clear helper for flags in other modules
  // Arming outlives break so a late second step still clears
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      two_step_armed_q <= 1'b0;
      two_step_clear_q <= 1'b0;
    end
    else
    begin
      two_step_clear_q <= two_step_armed_q && flag_step2 && flag_clear_ok;
      if (flag_step1)
      begin
        two_step_armed_q <= 1'b1;
      end
      else if (two_step_armed_q && flag_step2 && flag_clear_ok)
      begin
        // Once cleared nothing restores the flag after break
        two_step_armed_q <= 1'b0;
      end
    end
  end
  assign two_step_clear = two_step_clear_q;

  // Read mux; unused bits read zero
  always_comb
  begin
    rdata_d = '0;
    if (hit_bws)
    begin
      rdata_d[BIT_BREAK_EXITED_WAIT] = break_exited_wait_q;
    end
    else if (hit_rss)
    begin
      rdata_d[5:0] = rst_src_q;
    end
    else if (hit_bfc)
    begin
      rdata_d[BIT_BREAK_CLEAR_ENABLE] = break_clear_enable_q;
    end
  end
  assign prdata = apb_rd ? rdata_d : '0;
endmodule

//--- sim/elc_top_props.sv
// Assertion checker for the exception and low-power control block
`timescale 1ns/100ps
module elc_top_props
  import elc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cpu_imask,
  input wire logic instr_done,
  input wire logic swi_exec,
  input wire logic wait_exec,
  input wire logic stack_done,
  input wire logic int_req,
  input wire logic [VEC_W-1:0] int_vector,
  input wire logic push_pc_minus1,
  input wire logic set_imask,
  input wire logic clear_imask,
  input wire logic reset_req,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic clkgen_out_en,
  input wire logic sys_counter_clr
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_entry_sets_mask: assert property ($rose(int_req) |-> set_imask)
    else $error("entry without mask set");
  chk_vector_held: assert property (int_req && !stack_done |=>
    reset_req || (int_req && $stable(int_vector))) else $error("latched vector lost");
  chk_masked_hold: assert property (instr_done && cpu_imask && !swi_exec && !int_req
    && cpu_clk_en |=> !int_req) else $error("masked interrupt taken");
  chk_trap_entry: assert property (swi_exec && cpu_clk_en && !int_req |=>
    reset_req || (int_req && int_vector == VEC_SOFTWARE_TRAP)) else $error("trap not taken");
  chk_push_kind: assert property (int_req |->
    push_pc_minus1 == (int_vector != VEC_SOFTWARE_TRAP)) else $error("wrong stacked pc kind");
  chk_reset_first: assert property (reset_req |-> !int_req)
    else $error("interrupt beside reset");
  chk_wait_gates: assert property (wait_exec && cpu_clk_en && !int_req && !swi_exec
    && !instr_done |=> reset_req || (!cpu_clk_en && periph_clk_en && clear_imask))
    else $error("wait entry wrong");
  chk_stop_halts: assert property (!clkgen_out_en |->
    sys_counter_clr && !cpu_clk_en && !periph_clk_en) else $error("stop leaves clocks on");
endmodule

bind elc_top elc_top_props CHK (.pclk, .presetn, .cpu_imask, .instr_done, .swi_exec,
  .wait_exec, .stack_done, .int_req, .int_vector, .push_pc_minus1, .set_imask, .clear_imask,
  .reset_req, .cpu_clk_en, .periph_clk_en, .clkgen_out_en, .sys_counter_clr);

//--- sim/elc_cpu_model.sv
// Behavioural CPU core answering interrupt entry with a stacking done pulse
`timescale 1ns/100ps
module elc_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic int_req,
  input wire logic [3:0] lag,
  output logic stack_done
);
  logic [3:0] cnt_q;
  // Stacks registers but never index high; handlers save that themselves
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= 4'h0;
      stack_done <= 1'b0;
    end
    else if (!int_req || stack_done)
    begin
      cnt_q <= 4'h0;
      stack_done <= 1'b0;
    end
    else if (cnt_q == lag)
      stack_done <= 1'b1;
    else
      cnt_q <= cnt_q + 4'h1;
  end
endmodule

//--- sim/elc_top_test.sv
// Self-checking bench for the exception and low-power control block
`timescale 1ns/100ps
module elc_top_test;
  import elc_pkg::*;
  localparam logic [ADDR_W-1:0] BW_A = OFS_BREAK_WAIT_STATUS;
  localparam logic [ADDR_W-1:0] RS_A = OFS_RESET_SOURCE_STATUS;
  localparam logic [ADDR_W-1:0] BF_A = OFS_BREAK_FLAG_CONTROL;
  // Short stop recovery keeps the run brief
  localparam int REC = 8;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cpu_imask = 0, err;
  logic instr_done = 0, swi_exec = 0, wait_exec = 0, stop_exec = 0, ext_irq_n = 1, rti_exec = 0;
  logic break_mode = 0, watchdog_disable_cfg = 0, flag_step1 = 0, flag_step2 = 0;
  logic [ADDR_W-1:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [7:0] irq_pending = 0, irq_enable = 0;
  logic [5:0] evt = 0;
  logic [3:0] lag = 0;
  logic [VEC_W-1:0] int_vector;
  logic pready, pslverr, stack_done, int_req, push_pc_minus1, set_imask, clear_imask;
  logic reset_req, prefetch_discard, cpu_clk_en, periph_clk_en, clkgen_out_en;
  logic sys_counter_clr, watchdog_run, flag_clear_ok, two_step_clear;
  int miscompares = 0, cmp_count = 0, rsrc = 'h20, k, n, v;

  always #20 pclk = ~pclk;

  elc_top #(.RECOVERY_CYCLES(REC)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cpu_imask, .instr_done, .rti_exec, .swi_exec,
    .wait_exec, .stop_exec, .stack_done, .irq_pending, .irq_enable, .ext_irq_n, .break_mode,
    .por_evt(evt[5]), .pin_rst_evt(evt[4]), .watchdog_rst_evt(evt[3]), .bad_opcode_evt(evt[2]),
    .bad_fetch_evt(evt[1]), .low_voltage_evt(evt[0]), .watchdog_disable_cfg, .flag_step1,
    .flag_step2, .int_req, .int_vector, .push_pc_minus1, .set_imask, .clear_imask,
    .prefetch_discard, .reset_req, .cpu_clk_en, .periph_clk_en, .clkgen_out_en,
    .sys_counter_clr, .watchdog_run, .flag_clear_ok, .two_step_clear);
  elc_cpu_model CPU (.pclk, .presetn, .int_req, .lag, .stack_done);

  // Reference arbitration: lowest enabled index wins, mask blocks all
  function automatic int vec_exp(input logic [7:0] q, input logic m);
    vec_exp = 0;
    for (int i = 7; i >= 0; i--)
      if (q[i] && !m)
        vec_exp = i + 1;
  endfunction

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask

  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task rdchk(input string s, input logic [ADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, e, rd);
  endtask

  task settle();
    n = 0;
    while (int_req !== 1'b0 && n < 60)
    begin
      @(posedge pclk);
      #1 n++;
    end
    chk("settle", 0, int_req);
  endtask

  task test_done();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #(40 * 4000);
    miscompares++;
    test_done();
  end

  initial
  begin
    void'($urandom(44372));
    repeat (16) @(posedge pclk);
    presetn <= 1;
    watchdog_disable_cfg <= 1'($urandom);
    rdchk("rsrc", RS_A, rsrc);
    rdchk("rsrc", RS_A, 0);
    apb(1'b1, BF_A, 32'hffffffff);
    rdchk("break_clear_enable", BF_A, 1);
    apb(1'b0, 12'h00c, 32'h0);
    chk("slverr", 1, err);
    rsrc = 0;
    for (k = 0; k < 6; k++)
    begin
      @(posedge pclk) evt <= 6'h01 << k;
      @(posedge pclk) evt <= 0;
      rsrc = (k == 5) ? 'h20 : rsrc | (1 << k);
      #1 chk("reset_req", 1, reset_req);
      rdchk("rsrc", RS_A, rsrc);
      rsrc = 0;
    end
    // Power-on beside another source leaves only its own flag
    @(posedge pclk) evt <= 6'h30;
    @(posedge pclk) evt <= 0;
    rdchk("por wins", RS_A, 'h20);
    for (k = 0; k < 8; k++)
    begin
      @(posedge pclk);
      irq_pending <= 8'($urandom);
      irq_enable <= 8'($urandom);
      cpu_imask <= k[0];
      lag <= 4'($urandom);
      @(posedge pclk) instr_done <= 1;
      v = vec_exp(irq_pending & irq_enable, cpu_imask);
      @(posedge pclk) instr_done <= 0;
      #1;
      if (v != 0)
        chk("hw", {1'b1, v[3:0], 2'b10}, {int_req, int_vector, push_pc_minus1, prefetch_discard});
      else
        chk("no entry", 0, int_req);
      settle();
    end
    @(posedge pclk) irq_pending <= 0;
    cpu_imask <= 1;
    swi_exec <= 1;
    @(posedge pclk) swi_exec <= 0;
    #1 chk("trap", {1'b1, VEC_SOFTWARE_TRAP, 1'b0}, {int_req, int_vector, push_pc_minus1});
    settle();
    @(posedge pclk) wait_exec <= 1;
    @(posedge pclk) wait_exec <= 0;
    #1 chk("wait clocks", 3'b011, {cpu_clk_en, periph_clk_en, clear_imask});
    chk("watchdog", !watchdog_disable_cfg, watchdog_run);
    @(posedge pclk) break_mode <= 1;
    @(posedge pclk);
    #1 chk("break wake", 1, cpu_clk_en);
    rdchk("bflag", BW_A, 2);
    apb(1'b1, BF_A, 32'h0);
    apb(1'b1, BW_A, 32'h0);
    rdchk("bflag", BW_A, 2);
    @(posedge pclk) evt <= 6'h08;
    @(posedge pclk) evt <= 0;
    rdchk("bflag", BW_A, 0);
    rdchk("rsrc", RS_A, 8);
    rdchk("rsrc", RS_A, 8);
    apb(1'b1, BF_A, 32'h1);
    rdchk("rsrc", RS_A, 8);
    break_mode <= 0;
    rdchk("rsrc", RS_A, 0);
    // Flag set again, then cleared by software outside break
    @(posedge pclk) wait_exec <= 1;
    @(posedge pclk) wait_exec <= 0;
    break_mode <= 1;
    @(posedge pclk) break_mode <= 0;
    #1 chk("break exit", 1, cpu_clk_en);
    apb(1'b1, BW_A, 32'h2);
    rdchk("bflag", BW_A, 2);
    apb(1'b1, BW_A, 32'h0);
    rdchk("bflag", BW_A, 0);
    @(posedge pclk) wait_exec <= 1;
    @(posedge pclk) wait_exec <= 0;
    irq_pending <= 8'h08;
    irq_enable <= 8'h08;
    @(posedge pclk);
    #1 chk("wait wake", {1'b1, 4'h4}, {int_req, int_vector});
    @(posedge pclk) irq_pending <= 0;
    settle();
    @(posedge pclk) stop_exec <= 1;
    @(posedge pclk) stop_exec <= 0;
    irq_enable <= 8'h01;
    #1 chk("stop", 4'b0001, {cpu_clk_en, periph_clk_en, clkgen_out_en, sys_counter_clr});
    @(posedge pclk) ext_irq_n <= 0;
    settle();
    while (int_req !== 1'b1 && n < 40)
    begin
      @(posedge pclk);
      #1 n++;
    end
    // Two sync flops, one edge into recovery, then the recovery count
    chk("stop wake", 2 + 1 + REC, n);
    chk("stop vec", {1'b1, 4'h1}, {int_req, int_vector});
    @(posedge pclk) ext_irq_n <= 1;
    settle();
    apb(1'b1, BF_A, 32'h0);
    @(posedge pclk) flag_step1 <= 1;
    @(posedge pclk) flag_step1 <= 0;
    break_mode <= 1;
    @(posedge pclk) flag_step2 <= 1;
    @(posedge pclk) flag_step2 <= 0;
    #1 chk("step2 in break", 0, two_step_clear);
    chk("clear ok", 0, flag_clear_ok);
    @(posedge pclk) break_mode <= 0;
    @(posedge pclk) flag_step2 <= 1;
    @(posedge pclk) flag_step2 <= 0;
    #1 chk("step2 after", 1, two_step_clear);
    // Interrupt pending as a return ends
    @(posedge pclk) cpu_imask <= 0;
    irq_pending <= 8'h04;
    irq_enable <= 8'h04;
    rti_exec <= 1;
    @(posedge pclk) rti_exec <= 0;
    instr_done <= 1;
    @(posedge pclk) instr_done <= 0;
    irq_pending <= 0;
    #1 chk("rti entry", {1'b1, 4'h3, 1'b1}, {int_req, int_vector, prefetch_discard});
    settle();
    test_done();
  end
endmodule
